// File: core/radio_seq_consts.vh
// Constants of the radio command sequencer: register offsets, reset values
// and instruction opcodes.
// Assumes inclusion by the sequencer module only.
`ifndef RADIO_SEQ_CONSTS_VH
`define RADIO_SEQ_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_CMD       8'h00
`define OFS_CNT_X     8'h01
`define OFS_CNT_Y     8'h02
`define OFS_CNT_Z     8'h03
`define OFS_CTRL      8'h04
`define OFS_CMP_LO    8'h05
`define OFS_CMP_HI    8'h06
`define OFS_STATUS    8'h07

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_CPU_BIT  0
`define RST_BYTE      8'h00

// ****************************************************************
// Opcodes, wait count and strobe codes
// ****************************************************************
`define OP_WAIT_X     8'hbb
`define OP_WAIT_CMP   8'hb8
`define OP_LABEL      8'hba
`define OP_HALT       8'hdf
`define OP_IMM_HALT   8'hff
`define OP_IMM_RUN    8'hfe
`define OP_IMM_FIRST  8'he1
`define OP_IMM_LAST   8'he5
`define WAIT_ZERO_CNT 6'h20
`define STRB_RXON     4'h2
`define STRB_TXCCA    4'h4
`define STRB_LAST     4'h9

`endif

// File: core/radio_command_sequencer.v
// Command strobe sequencer: stores a program of one-byte instructions and
// issues command strobes to the radio core, with timer waits and loops.
// Assumes a single clock, synchronous radio and timer inputs, and a radio
// that acknowledges every strobe it is given.
`timescale 1ns/10ps
`include "radio_seq_consts.vh"

module radio_command_sequencer #(
	parameter DEPTH   = 24,
	parameter TIMER_W = 16
) (
	input  wire               clk,
	input  wire               nrst,
	input  wire               clkEn,
	// Host register port.
	input  wire [7:0]         regAddr,
	input  wire [7:0]         regWrData,
	input  wire               regWr,
	input  wire               regRd,
	output reg  [7:0]         regRdData_q,
	// Timer and radio side.
	input  wire               macTimerOverflow,
	input  wire [TIMER_W-1:0] macTimerValue,
	input  wire               clearChannel,
	input  wire               frameDelimiter,
	input  wire               radioAck,
	// Registered strobes and event pulses.
	output reg                radioStrobe_q,
	output reg  [3:0]         radioCmd_q,
	output reg                rxEnablePulse_q,
	output reg                waitDoneFlag_q,
	output reg                haltFlag_q
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN  = 3'b010;
	localparam [2:0] ST_ACK  = 3'b100;

	reg [2:0]         state_q;
	// The program lives in mem_q; wrPtr_q is the next free entry and also
	// the end of the program, so a run stops when pc_q reaches it.
	// label_q means nothing while labelValid_q is clear.
	reg [7:0]         mem_q [0:DEPTH-1];
	reg [4:0]         pc_q;
	reg [4:0]         wrPtr_q;
	reg [4:0]         label_q;
	reg               labelValid_q;
	reg [5:0]         waitCnt_q;
	reg               immPend_q;
	reg [3:0]         immCode_q;
	reg               ackImm_q;
	reg               runAfter_q;
	// Host registers; X doubles as the counter of the register wait.
	reg [7:0]         cntX_q;
	reg [7:0]         cntY_q;
	reg [7:0]         cntZ_q;
	reg               cpuCtrl_q;
	reg [TIMER_W-1:0] compare_q;

	wire [7:0] instr   = mem_q[pc_q];
	// A W field of zero stands for a full 32 overflows, hence six bits.
	wire [5:0] wTarget = (instr[4:0] == 5'h00) ?
		`WAIT_ZERO_CNT : {1'b0, instr[4:0]};
	wire [5:0] waitInc = waitCnt_q + 6'h01;
	wire       lastPc  = (pc_q == DEPTH[4:0] - 5'h01);

	// Loop index for clearing the program memory.
	integer i;

	// ****************************************************************
	// Condition select, shared by repeat and skip.
	// ****************************************************************
	// Code 7 is unused and reads as false, so with N set it is an
	// unconditional true; software relies on that for plain jumps.
	// The negate bit is applied after selection for every code.
	function condSel;
		input [2:0] c;
		input       negate;
		reg         v;
		begin
			case (c)
				3'd0: v = clearChannel;
				3'd1: v = frameDelimiter;
				3'd2: v = cpuCtrl_q;
				3'd3: v = lastPc;
				3'd4: v = (cntX_q == 8'h00);
				3'd5: v = (cntY_q == 8'h00);
				3'd6: v = (cntZ_q == 8'h00);
				default: v = 1'b0;
			endcase
			condSel = v ^ negate;
		end
	endfunction

	// A strobe code is a valid radio request from 1 up to the last code.
	function strobeValid;
		input [3:0] code;
		begin
			strobeValid = (code != 4'h0) && (code <= `STRB_LAST);
		end
	endfunction

	// ****************************************************************
	// Program counter step and register read selection
	// ****************************************************************
	// Five bits reach past the last entry, but the end-of-program test
	// stops the run before any such address is fetched.
	function [4:0] nextPc;
		input [4:0] pc;
		begin
			nextPc = pc + 5'h01;
		end
	endfunction

	// Unmapped offsets and the write-only command port read as zero.
	function [7:0] readMux;
		input [7:0] addr;
		begin
			if (addr == `OFS_CNT_X)
				readMux = cntX_q;
			else if (addr == `OFS_CNT_Y)
				readMux = cntY_q;
			else if (addr == `OFS_CNT_Z)
				readMux = cntZ_q;
			else if (addr == `OFS_CTRL)
				readMux = {7'h00, cpuCtrl_q};
			else if (addr == `OFS_CMP_LO)
				readMux = compare_q[7:0];
			else if (addr == `OFS_CMP_HI)
				readMux = compare_q[TIMER_W-1:8];
			else if (addr == `OFS_STATUS)
				readMux = {state_q[1], state_q[2], immPend_q, pc_q};
			else
				readMux = `RST_BYTE;
		end
	endfunction

	// ****************************************************************
	// Sequencer and register port
	// ****************************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			// Memory is cleared here too, so a half-loaded program left
			// from before a reset can never be started.
			state_q         <= ST_IDLE;
			for (i = 0; i < DEPTH; i = i + 1)
				mem_q[i] <= `RST_BYTE;
			pc_q            <= 5'h00;
			wrPtr_q         <= 5'h00;
			label_q         <= 5'h00;
			labelValid_q    <= 1'b0;
			waitCnt_q       <= 6'h00;
			immPend_q       <= 1'b0;
			immCode_q       <= 4'h0;
			ackImm_q        <= 1'b0;
			runAfter_q      <= 1'b0;
			cntX_q          <= `RST_BYTE;
			cntY_q          <= `RST_BYTE;
			cntZ_q          <= `RST_BYTE;
			cpuCtrl_q       <= 1'b0;
			compare_q       <= {TIMER_W{1'b0}};
			regRdData_q     <= `RST_BYTE;
			radioStrobe_q   <= 1'b0;
			radioCmd_q      <= 4'h0;
			rxEnablePulse_q <= 1'b0;
			waitDoneFlag_q  <= 1'b0;
			haltFlag_q      <= 1'b0;
		end else if (clkEn) begin
			radioStrobe_q   <= 1'b0;
			rxEnablePulse_q <= 1'b0;
			waitDoneFlag_q  <= 1'b0;
			haltFlag_q      <= 1'b0;

			// ****************************************
			// Instruction execution
			// ****************************************
			case (state_q)
				ST_ACK: begin
					// Nothing else is issued here: a radio that never
					// answers stalls the sequencer until a host halt or run command.
					if (radioAck) begin
						if (ackImm_q)
							state_q <= runAfter_q ? ST_RUN : ST_IDLE;
						else begin
							pc_q    <= nextPc(pc_q);
							state_q <= ST_RUN;
						end
					end
				end
				ST_IDLE, ST_RUN: begin
					if (immPend_q) begin
						// The running instruction is simply not looked at
						// this cycle, so it resumes where it stood.
						immPend_q  <= 1'b0;
						runAfter_q <= (state_q == ST_RUN);
						if (immCode_q != `STRB_TXCCA || clearChannel) begin
							radioStrobe_q   <= 1'b1;
							radioCmd_q      <= immCode_q;
							rxEnablePulse_q <= (immCode_q == `STRB_RXON);
							ackImm_q        <= 1'b1;
							state_q         <= ST_ACK;
						end
					end else if (state_q == ST_RUN) begin
						if (pc_q >= wrPtr_q)
							state_q <= ST_IDLE;
						else if (!instr[7]) begin
							if (condSel(instr[2:0], instr[3]))
								pc_q <= pc_q + {2'b00, instr[6:4]} +
									5'h01;
							else if (instr[6:4] != 3'h0)
								pc_q <= pc_q + 5'h01;
							// A zero skip length just holds here.
						end else if (instr[7:5] == 3'b100) begin
							// Overflows are counted in waitCnt_q, not in the
							// stored byte, so the program can be rerun as
							// it stands.
							if (macTimerOverflow) begin
								if (waitInc == wTarget) begin
									waitCnt_q      <= 6'h00;
									pc_q           <= pc_q + 5'h01;
									waitDoneFlag_q <= 1'b1;
								end else
									waitCnt_q <= waitInc;
							end
						end else if (instr == `OP_WAIT_X) begin
							// X itself is counted down, so software can read
							// back how many overflows are still owed.
							if (cntX_q == 8'h00) begin
								pc_q           <= pc_q + 5'h01;
								waitDoneFlag_q <= 1'b1;
							end else if (macTimerOverflow) begin
								cntX_q <= cntX_q - 8'h01;
								if (cntX_q == 8'h01) begin
									pc_q           <= pc_q + 5'h01;
									waitDoneFlag_q <= 1'b1;
								end
							end
						end else if (instr == `OP_WAIT_CMP) begin
							if (macTimerValue >= compare_q)
								pc_q <= pc_q + 5'h01;
						end else if (instr == `OP_LABEL) begin
							// At the last entry the label points at itself,
							// as there is no next entry to loop back to.
							label_q      <= lastPc ? pc_q :
								pc_q + 5'h01;
							labelValid_q <= 1'b1;
							pc_q         <= pc_q + 5'h01;
						end else if (instr[7:4] == 4'ha) begin
							if (labelValid_q &&
								condSel(instr[2:0], instr[3]))
								pc_q <= label_q;
							else
								pc_q <= pc_q + 5'h01;
						end else if (instr == `OP_HALT) begin
							// Unlike running off the end, a halt drops the
							// program, so it must be loaded again.
							state_q      <= ST_IDLE;
							for (i = 0; i < DEPTH; i = i + 1)
								mem_q[i] <= `RST_BYTE;
							pc_q         <= 5'h00;
							wrPtr_q      <= 5'h00;
							labelValid_q <= 1'b0;
							haltFlag_q   <= 1'b1;
						end else if (instr[7:5] == 3'b110 &&
							strobeValid(instr[3:0])) begin
							// A busy channel turns the conditional transmit
							// into a plain advance, so no ack is owed.
							if (instr[3:0] == `STRB_TXCCA &&
								!clearChannel)
								pc_q <= pc_q + 5'h01;
							else begin
								radioStrobe_q   <= 1'b1;
								radioCmd_q      <= instr[3:0];
								rxEnablePulse_q <=
									(instr[3:0] == `STRB_RXON);
								ackImm_q        <= 1'b0;
								state_q         <= ST_ACK;
							end
						end else
							pc_q <= nextPc(pc_q);
					end
				end
				default: state_q <= ST_IDLE;
			endcase

			// ****************************************
			// Host command port and registers
			// ****************************************
			// Host writes come last so they win over the sequencer in
			// the same cycle.
			if (regWr) begin
				if (regAddr == `OFS_CMD) begin
					if (regWrData == `OP_IMM_HALT) begin
						state_q      <= ST_IDLE;
						for (i = 0; i < DEPTH; i = i + 1)
							mem_q[i] <= `RST_BYTE;
						pc_q         <= 5'h00;
						wrPtr_q      <= 5'h00;
						labelValid_q <= 1'b0;
						immPend_q    <= 1'b0;
						waitCnt_q    <= 6'h00;
						haltFlag_q   <= 1'b1;
					end else if (regWrData == `OP_IMM_RUN) begin
						// An acknowledge still owed is dropped here.
						pc_q      <= 5'h00;
						waitCnt_q <= 6'h00;
						state_q   <= ST_RUN;
					end else if (regWrData >= `OP_IMM_FIRST &&
						regWrData <= `OP_IMM_LAST) begin
						immPend_q <= 1'b1;
						immCode_q <= regWrData[3:0];
					end else if (regWrData[7:5] != 3'b111 &&
						wrPtr_q < DEPTH[4:0]) begin
						mem_q[wrPtr_q] <= regWrData;
						wrPtr_q        <= wrPtr_q + 5'h01;
					end
				end else if (regAddr == `OFS_CNT_X)
					cntX_q <= regWrData;
				else if (regAddr == `OFS_CNT_Y)
					cntY_q <= regWrData;
				else if (regAddr == `OFS_CNT_Z)
					cntZ_q <= regWrData;
				else if (regAddr == `OFS_CTRL)
					cpuCtrl_q <= regWrData[`CTRL_CPU_BIT];
				else if (regAddr == `OFS_CMP_LO)
					compare_q[7:0] <= regWrData;
				else if (regAddr == `OFS_CMP_HI)
					compare_q[TIMER_W-1:8] <= regWrData[TIMER_W-9:0];
			end

			// ****************************************
			// Register reads
			// ****************************************
			// Read data is registered: it stands in the cycle after the
			// read strobe and holds until the next read.
			if (regRd)
				regRdData_q <= readMux(regAddr);
		end
	end

endmodule

// File: verif/radio_seq_sva.sv
// Assertions on the ports of the radio command sequencer.
// Assumes one clock domain and clkEn held high.
`timescale 1ns/10ps
module radio_seq_sva (
	input wire       clk,
	input wire       nrst,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire       regWr,
	input wire       clearChannel,
	input wire       radioAck,
	input wire       radioStrobe_q,
	input wire [3:0] radioCmd_q,
	input wire       rxEnablePulse_q,
	input wire       waitDoneFlag_q,
	input wire       haltFlag_q
);
	reg pend_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ****************************************************************
	// Outstanding strobe tracker
	// ****************************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			pend_q <= 1'b0;
		else if (radioStrobe_q)
			pend_q <= 1'b1;
		else if (radioAck)
			pend_q <= 1'b0;
	end
	a_ack_first: assert property (radioStrobe_q |-> !pend_q)
		else $error("strobe issued before the previous ack");
	a_strobe_gap: assert property (radioStrobe_q |=> !radioStrobe_q [*2])
		else $error("strobes too close");
	a_rx_pulse: assert property (rxEnablePulse_q == (radioStrobe_q && radioCmd_q == 4'h2))
		else $error("rx enable pulse wrong");
	a_cca_gate: assert property (radioStrobe_q && radioCmd_q == 4'h4 |-> $past(clearChannel))
		else $error("conditional tx on busy channel");
	a_cmd_legal: assert property (radioStrobe_q |-> radioCmd_q != 4'h0 && radioCmd_q <= 4'h9)
		else $error("illegal strobe code");
	a_cmd_hold: assert property (!radioStrobe_q |-> $stable(radioCmd_q))
		else $error("strobe code changed without strobe");
	a_halt_write: assert property (regWr && regAddr == 8'h00 && regWrData == 8'hff |=> haltFlag_q)
		else $error("no halt flag after immediate halt");
	a_halt_quiet: assert property (haltFlag_q && !regWr ##1 !regWr |-> !radioStrobe_q)
		else $error("strobe after halt");
	a_wait_excl: assert property (waitDoneFlag_q |-> !radioStrobe_q)
		else $error("strobe in the cycle of wait completion");
endmodule
bind radio_command_sequencer radio_seq_sva chk_u (.clk(clk), .nrst(nrst),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.clearChannel(clearChannel), .radioAck(radioAck),
	.radioStrobe_q(radioStrobe_q), .radioCmd_q(radioCmd_q),
	.rxEnablePulse_q(rxEnablePulse_q), .waitDoneFlag_q(waitDoneFlag_q),
	.haltFlag_q(haltFlag_q));

// File: verif/radio_model.sv
// Radio model: acknowledges every strobe after a chosen delay.
// Assumes at most one strobe outstanding.
`timescale 1ns/10ps
module radio_model (
	input  wire       clk,
	input  wire       nrst,
	input  wire       strobe,
	input  wire [3:0] slow,
	output reg        ack_q
);
	reg       busy_q;
	reg [3:0] cnt_q;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			ack_q <= 1'b0;
			if (strobe) begin
				busy_q <= 1'b1;
				cnt_q <= slow;
			end else if (busy_q && cnt_q == 4'h0) begin
				ack_q <= 1'b1;
				busy_q <= 1'b0;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule

// File: verif/tb.sv
// Testbench of the radio command sequencer beside a radio model.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/10ps
module tb;
	localparam [31:0] CODES = 32'h12356789;
	reg         clk = 1'b0;
	reg         nrst = 1'b0;
	reg  [7:0]  regAddr = 8'h00;
	reg  [7:0]  regWrData = 8'h00;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg         macTimerOverflow = 1'b0;
	reg  [15:0] macTimerValue = 16'h0000;
	reg         clearChannel = 1'b0;
	reg         frameDelimiter = 1'b0;
	reg  [3:0]  slow = 4'h0;
	wire [7:0]  regRdData_q;
	wire [3:0]  radioCmd_q;
	wire        radioAck, radioStrobe_q, rxEnablePulse_q;
	wire        waitDoneFlag_q, haltFlag_q;
	integer     n_fail = 0;
	integer     comparisons = 0;
	integer     nStr = 0;
	integer     nWait = 0;
	integer     nHalt = 0;
	integer     nRx = 0;
	integer     k, s;
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) begin
		nStr <= nStr + radioStrobe_q;
		nWait <= nWait + waitDoneFlag_q;
		nHalt <= nHalt + haltFlag_q;
		nRx <= nRx + rxEnablePulse_q;
	end
	radio_command_sequencer dut_u (.clk(clk), .nrst(nrst), .clkEn(1'b1),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData_q(regRdData_q),
		.macTimerOverflow(macTimerOverflow), .macTimerValue(macTimerValue),
		.clearChannel(clearChannel), .frameDelimiter(frameDelimiter),
		.radioAck(radioAck), .radioStrobe_q(radioStrobe_q),
		.radioCmd_q(radioCmd_q), .rxEnablePulse_q(rxEnablePulse_q),
		.waitDoneFlag_q(waitDoneFlag_q), .haltFlag_q(haltFlag_q));
	radio_model radio_u (.clk(clk), .nrst(nrst), .strobe(radioStrobe_q),
		.slow(slow), .ack_q(radioAck));
	task finish_test;
		begin
			if (n_fail == 0 && comparisons > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			regWr <= 1'b1;
			regAddr <= a;
			regWrData <= d;
			@(posedge clk);
			regWr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge clk);
			regRd <= 1'b1;
			regAddr <= a;
			@(posedge clk);
			regRd <= 1'b0;
			#1;
			chk("rd", e, regRdData_q);
		end
	endtask
	task ld(input [127:0] p, input integer n);
		integer j;
		for (j = n - 1; j >= 0; j = j - 1)
			wr(8'h00, p[8*j +: 8]);
	endtask
	task ovf;
		begin
			tick(3);
			macTimerOverflow <= 1'b1;
			tick(1);
			macTimerOverflow <= 1'b0;
			tick(3);
		end
	endtask
	// Waits for the next strobe; a strobe already seen is stepped past.
	task expStr(input [3:0] c);
		integer i;
		begin
			i = 0;
			do begin
				@(posedge clk);
				#1;
				i = i + 1;
			end while (radioStrobe_q !== 1'b1 && i < 300);
			if (i >= 300) begin
				n_fail = n_fail + 1;
				finish_test;
			end else
				chk("cmd", c, radioCmd_q);
		end
	endtask
	task s_prog;
		begin
			rd(8'h01, 8'h00);
			wr(8'h01, 8'h02);
			rd(8'h01, 8'h02);
			rd(8'h40, 8'h00);
			wr(8'h05, 8'h10);
			macTimerValue <= 16'h000f;
			ld(128'hc4c1c2c3c5c6c7c8c9bb82b8df, 13);
			wr(8'h00, 8'hfe);
			for (k = 7; k >= 0; k = k - 1)
				expStr(CODES[4*k +: 4]);
			chk("rx", 1, nRx);
			ovf;
			chk("wait", 0, nWait);
			wr(8'h00, 8'he3);
			expStr(4'h3);
			ovf;
			chk("wait", 1, nWait);
			rd(8'h01, 8'h00);
			ovf;
			chk("wait", 1, nWait);
			ovf;
			chk("wait", 2, nWait);
			tick(10);
			chk("halt", 0, nHalt);
			macTimerValue <= 16'h0010;
			tick(10);
			chk("halt", 1, nHalt);
			s = nStr;
			wr(8'h00, 8'hfe);
			tick(20);
			chk("strobes", s, nStr);
		end
	endtask
	task s_imm;
		begin
			clearChannel <= 1'b1;
			for (k = 1; k <= 4; k = k + 1) begin
				wr(8'h00, 8'he0 + k[7:0]);
				expStr(k[3:0]);
			end
			s = nHalt;
			wr(8'h00, 8'hff);
			tick(3);
			chk("halt", s + 1, nHalt);
		end
	endtask
	task s_loop;
		begin
			slow <= 4'h3;
			frameDelimiter <= 1'b1;
			ld(128'hbac5a111c6c0cac7, 8);
			wr(8'h00, 8'hfe);
			expStr(4'h5);
			expStr(4'h5);
			@(posedge clk);
			frameDelimiter <= 1'b0;
			expStr(4'h6);
			expStr(4'h7);
			tick(10);
			wr(8'h00, 8'hfe);
			expStr(4'h5);
			expStr(4'h6);
			expStr(4'h7);
		end
	endtask
	task s_skip;
		begin
			wr(8'h00, 8'hff);
			ld(128'h0121c1c2c3, 5);
			s = nStr;
			wr(8'h00, 8'hfe);
			tick(20);
			chk("strobes", s, nStr);
			frameDelimiter <= 1'b1;
			expStr(4'h3);
			frameDelimiter <= 1'b0;
			wr(8'h00, 8'hff);
			ld(128'h80, 1);
			s = nWait;
			wr(8'h00, 8'hfe);
			for (k = 0; k < 31; k = k + 1)
				ovf;
			chk("wait", s, nWait);
			ovf;
			chk("wait", s + 1, nWait);
		end
	endtask
	initial begin
		tick(20);
		nrst <= 1'b1;
		s_prog;
		s_imm;
		s_loop;
		s_skip;
		finish_test;
	end
endmodule
